/* File: hw/rspf_filter.sv */
/*
 digital glitch filter: output follows input after it holds a new level for a number of enable ticks.
 assumes a synchronised input and a one-cycle tick enable on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rspf_filter #(
   parameter int CW = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic tick,
   input wire logic din,
   input wire logic [CW-1:0] count,
   output logic dout
);
   import rspf_pkg::*;
   logic [CW-1:0] run;
   // clear returns to the released (high) level so a stale low is never kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= '0;
         dout <= 1'b1;
      end else if (clear) begin
         run <= '0;
         dout <= 1'b1;
      end else if (din == dout) begin
         run <= '0;
      end else if (tick) begin
         if (run + 1'b1 >= count) begin
            dout <= din;
            run <= '0;
         end else begin
            run <= run + 1'b1;
         end
      end
   end
endmodule // rspf_filter
`default_nettype wire

/* File: hw/rspf_pkg.sv */
/*
 package of constants for the reset source status and reset pin filter block.
 assumes a 32-bit apb slave, byte addresses = index * 4 since printed offsets are not all multiples of four.
*/
// How it works
// - read-only second reset cause status register
// - cleared on por, low-voltage, deep-stop wakeup
// - bit 5: stop acknowledge timeout reset
// - bit 3: debugger reset request
// - bit 2: software reset request
// - bit 1: core lockup reset
// - reserved bits always read zero
// - control bits 2:0 reset only by por
// - filters cleared when disabled; bus filter also cleared when stopping
// - control bit 2 selects stop-mode filtering
// - run/wait select: off, bus, oscillator, reserved
// - bus filter count is width plus one
// - width field reset only by por
// - reset pin asserted when low
package rspf_pkg;
   localparam logic [11:0] RSPF_IDX_STATUS = 12'h001;
   localparam logic [11:0] RSPF_IDX_CONTROL = 12'h004;
   localparam logic [11:0] RSPF_IDX_WIDTH = 12'h005;
   localparam logic [11:0] RSPF_IDX_IRQ_STATUS = 12'h010;
   localparam logic [11:0] RSPF_IDX_IRQ_ENABLE = 12'h011;
   localparam logic [11:0] RSPF_IDX_IRQ_CLEAR = 12'h012;
   localparam logic [11:0] RSPF_ADDR_STATUS = {RSPF_IDX_STATUS[9:0], 2'b00};
   localparam logic [11:0] RSPF_ADDR_CONTROL = {RSPF_IDX_CONTROL[9:0], 2'b00};
   localparam logic [11:0] RSPF_ADDR_WIDTH = {RSPF_IDX_WIDTH[9:0], 2'b00};
   localparam logic [11:0] RSPF_ADDR_IRQ_STATUS = {RSPF_IDX_IRQ_STATUS[9:0], 2'b00};
   localparam logic [11:0] RSPF_ADDR_IRQ_ENABLE = {RSPF_IDX_IRQ_ENABLE[9:0], 2'b00};
   localparam logic [11:0] RSPF_ADDR_IRQ_CLEAR = {RSPF_IDX_IRQ_CLEAR[9:0], 2'b00};
   localparam int RSPF_BIT_STOP_ACK = 5;
   localparam int RSPF_BIT_DEBUG = 3;
   localparam int RSPF_BIT_SOFTWARE = 2;
   localparam int RSPF_BIT_LOCKUP = 1;
   localparam logic [7:0] RSPF_STATUS_MASK = 8'h2E;
   localparam logic [7:0] RSPF_STATUS_RESET = 8'h00;
   localparam logic [2:0] RSPF_CONTROL_RESET = 3'h0;
   localparam logic [4:0] RSPF_WIDTH_RESET = 5'h00;
   localparam int RSPF_BIT_STOP_SEL = 2;
   localparam int RSPF_IRQ_BITS = 2;
   localparam int RSPF_IRQ_BIT_ASSERT = 0;
   localparam int RSPF_IRQ_BIT_RELEASE = 1;
   localparam int RSPF_OSC_COUNT = 2;
   typedef enum logic [1:0] {
      RSPF_RW_OFF = 2'h0,
      RSPF_RW_BUS = 2'h1,
      RSPF_RW_OSC = 2'h2,
      RSPF_RW_RSVD = 2'h3
   } rspf_rw_sel_t;
endpackage

/* File: hw/rspf_top.sv */
/*
 reset cause status register b, reset pin filter control and width, apb slave, event interrupt.
 assumes reset cause strobes are levels held through the system reset, and por_n is the chip power-on reset
 (asynchronous, active low) separate from presetn. the oscillator tick is a pulse on pclk.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rspf_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic clear_cause,
   input wire logic cause_stop_ack,
   input wire logic cause_debug,
   input wire logic cause_software,
   input wire logic cause_lockup,
   input wire logic stop_mode,
   input wire logic low_power_oscillator_tick,
   input wire logic reset_pin_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pin_reset_req,
   output logic irq
);
   import rspf_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] cause;
   logic [2:0] control;
   logic [4:0] width;
   logic pin_s1, pin_s2;
   logic bus_out, osc_out;
   logic pin_filtered, pin_prev;
   logic [RSPF_IRQ_BITS-1:0] irq_status, irq_enable;
   logic wr, rd, hit;
   rspf_rw_sel_t rw_sel;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign rw_sel = rspf_rw_sel_t'(control[1:0]);
   always_comb begin
      case (paddr)
         RSPF_ADDR_STATUS, RSPF_ADDR_CONTROL, RSPF_ADDR_WIDTH,
         RSPF_ADDR_IRQ_STATUS, RSPF_ADDR_IRQ_ENABLE, RSPF_ADDR_IRQ_CLEAR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////////
   // cause record: captured at every system reset release, zero after por/low-voltage/wakeup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= RSPF_STATUS_RESET;
      end else if (clear_cause) begin
         cause <= RSPF_STATUS_RESET;
      end else begin
         cause[RSPF_BIT_STOP_ACK] <= cause[RSPF_BIT_STOP_ACK] | cause_stop_ack;
         cause[RSPF_BIT_DEBUG] <= cause[RSPF_BIT_DEBUG] | cause_debug;
         cause[RSPF_BIT_SOFTWARE] <= cause[RSPF_BIT_SOFTWARE] | cause_software;
         cause[RSPF_BIT_LOCKUP] <= cause[RSPF_BIT_LOCKUP] | cause_lockup;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // filter settings live on the power-on reset so other resets keep them
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         control <= RSPF_CONTROL_RESET;
         width <= RSPF_WIDTH_RESET;
      end else if (wr && paddr == RSPF_ADDR_CONTROL) begin
         control <= pwdata[2:0];
      end else if (wr && paddr == RSPF_ADDR_WIDTH) begin
         width <= pwdata[4:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         pin_s1 <= reset_pin_n;
         pin_s2 <= pin_s1;
      end
   end
   logic bus_en, osc_en;
   // reserved run/wait code behaves as unfiltered
   assign bus_en = !stop_mode && rw_sel == RSPF_RW_BUS;
   assign osc_en = stop_mode ? control[RSPF_BIT_STOP_SEL] : rw_sel == RSPF_RW_OSC;
   rspf_filter #(.CW(6)) u_bus_filter (
      .pclk(pclk),
      .presetn(presetn),
      .clear(!bus_en || stop_mode),
      .tick(1'b1),
      .din(pin_s2),
      .count({1'b0, width} + 6'h01),
      .dout(bus_out)
   );
   rspf_filter #(.CW(6)) u_osc_filter (
      .pclk(pclk),
      .presetn(presetn),
      .clear(!osc_en),
      .tick(low_power_oscillator_tick),
      .din(pin_s2),
      .count(6'(RSPF_OSC_COUNT)),
      .dout(osc_out)
   );
   always_comb begin
      if (bus_en) pin_filtered = bus_out;
      else if (osc_en) pin_filtered = osc_out;
      else pin_filtered = pin_s2;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reset_req <= 1'b0;
         pin_prev <= 1'b1;
      end else begin
         pin_reset_req <= !pin_filtered;
         pin_prev <= pin_filtered;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // interrupt events: filtered pin asserting and releasing; set beats clear
   logic [RSPF_IRQ_BITS-1:0] ev, clr;
   assign ev = {pin_filtered & !pin_prev, !pin_filtered & pin_prev};
   assign clr = (wr && paddr == RSPF_ADDR_IRQ_CLEAR) ? pwdata[RSPF_IRQ_BITS-1:0] : '0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_status <= '0;
      else irq_status <= (irq_status & ~clr) | ev;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_enable <= '0;
      else if (wr && paddr == RSPF_ADDR_IRQ_ENABLE) irq_enable <= pwdata[RSPF_IRQ_BITS-1:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= |(((irq_status & ~clr) | ev) & irq_enable);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // apb: no wait states; read data latched in setup, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         case (paddr)
            RSPF_ADDR_STATUS: prdata <= {24'h000000, cause & RSPF_STATUS_MASK};
            RSPF_ADDR_CONTROL: prdata <= {29'h00000000, control};
            RSPF_ADDR_WIDTH: prdata <= {27'h0000000, width};
            RSPF_ADDR_IRQ_STATUS: prdata <= {30'h00000000, irq_status};
            RSPF_ADDR_IRQ_ENABLE: prdata <= {30'h00000000, irq_enable};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (!hit || (pwrite && paddr == RSPF_ADDR_STATUS));
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // samples the synchronised pin has held its level, saturating; a lower bound for any filter decision
   logic [5:0] ast_hold;
   logic ast_last;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ast_hold <= 6'h00;
         ast_last <= 1'b1;
      end else begin
         ast_last <= pin_s2;
         if (pin_s2 != ast_last) ast_hold <= 6'h01;
         else if (ast_hold != 6'h3F) ast_hold <= ast_hold + 6'h01;
      end
   end
   AST_STATUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
      pready && !pwrite && $past(paddr) == RSPF_ADDR_STATUS |-> prdata[7:6] == 2'b00 && !prdata[4] && !prdata[0])
      else $error("status reserved bit read nonzero");
   AST_CAUSE_SOFT: assert property (@(posedge pclk) disable iff (!presetn)
      cause_software && !clear_cause |=> cause[RSPF_BIT_SOFTWARE])
      else $error("software cause not recorded");
   AST_CAUSE_DBG: assert property (@(posedge pclk) disable iff (!presetn)
      cause_debug && !clear_cause |=> cause[RSPF_BIT_DEBUG])
      else $error("debug cause not recorded");
   AST_CAUSE_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      cause_stop_ack && !clear_cause |=> cause[RSPF_BIT_STOP_ACK])
      else $error("stop ack cause not recorded");
   AST_CAUSE_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
      cause_lockup && !clear_cause |=> cause[RSPF_BIT_LOCKUP])
      else $error("lockup cause not recorded");
   AST_CAUSE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      clear_cause |=> cause == 8'h00)
      else $error("cause not cleared");
   AST_STATUS_RO: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == RSPF_ADDR_STATUS && !clear_cause && !cause_stop_ack && !cause_debug && !cause_software
      && !cause_lockup |=> $stable(cause) && $stable(control) && $stable(width))
      else $error("status write disturbed state");
   AST_BUS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode |=> bus_out)
      else $error("bus filter not cleared in stop");
   AST_BUS_MIN: assert property (@(posedge pclk) disable iff (!presetn)
      bus_out != $past(bus_out) && $past(bus_en) |-> ast_hold >= {1'b0, $past(width)} + 6'h01)
      else $error("bus filter accepted early");
   AST_PIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      !bus_en && !osc_en && !pin_s2 |=> pin_reset_req)
      else $error("low pin not treated as asserted");
   AST_STOP_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode && !control[RSPF_BIT_STOP_SEL] |-> !osc_en && !bus_en)
      else $error("stop filtering not disabled");
   COV_SOFT: cover property (@(posedge pclk) cause_software ##1 pready);
   COV_PIN: cover property (@(posedge pclk) bus_en ##1 !bus_out);
   COV_OSC: cover property (@(posedge pclk) stop_mode && osc_en ##1 !osc_out);
   COV_IRQ: cover property (@(posedge pclk) $rose(irq));
endmodule // rspf_top
`default_nettype wire

/* File: tb/rspf_src.sv */
/*
 model of the far side: external reset pin, free running low power oscillator ticks and internal reset cause levels.
 assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module rspf_src (
   input wire logic pclk,
   output logic reset_pin_n,
   output logic low_power_oscillator_tick,
   output logic [3:0] cause
);
   int osc_cnt = 0;
   initial begin
      reset_pin_n = 1'b1;
      low_power_oscillator_tick = 1'b0;
      cause = 4'h0;
   end
   // the oscillator never stops, it is the only clock in deep stop
   always @(posedge pclk) begin
      osc_cnt <= (osc_cnt + 1) % 8;
      low_power_oscillator_tick <= (osc_cnt == 7);
   end
   ////////////////////////////////////////////////////////////////
   // pin idles high, low is asserted
   task automatic pin_low(input int n);
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge pclk);
      reset_pin_n <= 1'b1;
   endtask
   // a cause level is held across the system reset it provokes
   task automatic cause_set(input int i, input logic v);
      @(posedge pclk);
      cause[i] <= v;
   endtask
endmodule // rspf_src
`default_nettype wire

/* File: tb/rspf_top_test.sv */
/*
 self-checking bench for the reset cause record, the pin filter registers and the filter itself.
 assumes the apb slave answers in its own time and the partner model drives pin, oscillator ticks and causes.
*/
`timescale 1ns/1ns
`default_nettype none
module rspf_top_test;
   import rspf_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, clear_cause = 1'b0, stop_mode = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, seen = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin_reset_req, irq, reset_pin_n, osc_tick;
   logic [3:0] cause;
   int n_fail = 0, checks = 0;
   int bits [4] = '{1, 2, 3, 5};
   logic [2:0] ctl [9] = '{3'h1, 3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h1, 3'h2, 3'h5};
   logic stp [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   int len [9] = '{3, 6, 1, 1, 3, 3, 1, 20, 20};
   logic pass [9] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   always #4 pclk = ~pclk;
   always @(posedge pclk) if (pin_reset_req === 1'b1) seen <= 1'b1;
   rspf_top rspf_top_i (.pclk(pclk), .presetn(presetn), .por_n(por_n), .clear_cause(clear_cause),
      .cause_stop_ack(cause[3]), .cause_debug(cause[2]), .cause_software(cause[1]),
      .cause_lockup(cause[0]), .stop_mode(stop_mode), .low_power_oscillator_tick(osc_tick),
      .reset_pin_n(reset_pin_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_reset_req(pin_reset_req), .irq(irq));
   rspf_src rspf_src_i (.pclk(pclk), .reset_pin_n(reset_pin_n), .low_power_oscillator_tick(osc_tick),
      .cause(cause));
   ////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until pready is sampled high, then released
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // a slave that never answers is ended by the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic sys_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic filt(input int n, input logic exp);
      seen <= 1'b0;
      rspf_src_i.pin_low(n);
      repeat (40) @(posedge pclk);
      chk("pin_req_seen", {31'h0, seen}, {31'h0, exp});
      chk("pin_req_idle", {31'h0, pin_reset_req}, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #(8 * 20000);
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      apb(0, RSPF_ADDR_STATUS, 0);
      chk("status_por", rd, 32'h0);
      chk("status_err", {31'h0, err}, 32'h0);
      apb(0, RSPF_ADDR_CONTROL, 0);
      chk("control_por", rd, 32'h0);
      apb(0, RSPF_ADDR_WIDTH, 0);
      chk("width_por", rd, 32'h0);
      apb(1, RSPF_ADDR_CONTROL, 32'hFFFFFFFF);
      apb(1, RSPF_ADDR_WIDTH, 32'hFFFFFFFF);
      sys_reset();
      apb(0, RSPF_ADDR_CONTROL, 0);
      chk("control_kept", rd, 32'h7);
      apb(0, RSPF_ADDR_WIDTH, 0);
      chk("width_kept", rd, 32'h1F);
      // each source alone, record cleared by the reset itself
      for (int i = 0; i < 4; i++) begin
         rspf_src_i.cause_set(i, 1'b1);
         sys_reset();
         rspf_src_i.cause_set(i, 1'b0);
         apb(0, RSPF_ADDR_STATUS, 0);
         chk("status_cause", rd, 32'h1 << bits[i]);
      end
      apb(1, RSPF_ADDR_STATUS, 32'hFF);
      chk("status_wr_err", {31'h0, err}, 32'h1);
      apb(0, RSPF_ADDR_STATUS, 0);
      chk("status_ro", rd, 32'h20);
      @(posedge pclk);
      clear_cause <= 1'b1;
      @(posedge pclk);
      clear_cause <= 1'b0;
      apb(0, RSPF_ADDR_STATUS, 0);
      chk("status_clr", rd, 32'h0);
      apb(0, 12'hFFC, 0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      // count of four: three cycles is a glitch, six is accepted
      apb(1, RSPF_ADDR_WIDTH, 32'h3);
      for (int i = 0; i < 9; i++) begin
         apb(1, RSPF_ADDR_CONTROL, {29'h0, ctl[i]});
         stop_mode <= stp[i];
         filt(len[i], pass[i]);
      end
      stop_mode <= 1'b0;
      apb(1, RSPF_ADDR_CONTROL, 32'h0);
      apb(1, RSPF_ADDR_IRQ_CLEAR, 32'h3);
      apb(1, RSPF_ADDR_IRQ_ENABLE, 32'h1);
      filt(2, 1'b1);
      chk("irq_on", {31'h0, irq}, 32'h1);
      apb(0, RSPF_ADDR_IRQ_STATUS, 0);
      chk("irq_status", rd, 32'h3);
      apb(1, RSPF_ADDR_IRQ_ENABLE, 32'h2);
      apb(1, RSPF_ADDR_IRQ_CLEAR, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      apb(0, RSPF_ADDR_IRQ_STATUS, 0);
      chk("irq_cleared", rd, 32'h1);
      end_sim();
   end
endmodule // rspf_top_test
`default_nettype wire
